// file: odd_pkg.sv
// Purpose: Shared constants and types for the output bank D configuration block
// Assumes: Byte-wide register port, one clock, active-low asynchronous reset
// Notes:   Ratio table index is the 6-bit coded ratio; zero marks a reserved code
package odd_pkg;

	// Register offsets
	localparam logic [7:0] ODD_ADDR_FRAC_LO  = 8'h28;
	localparam logic [7:0] ODD_ADDR_FRAC_MID = 8'h29;
	localparam logic [7:0] ODD_ADDR_FRAC_HI  = 8'h2A;
	localparam logic [7:0] ODD_ADDR_FINT     = 8'h2B;
	localparam logic [7:0] ODD_ADDR_RATIO    = 8'h2C;
	localparam logic [7:0] ODD_ADDR_PATH     = 8'h2D;
	localparam logic [7:0] ODD_ADDR_PWR      = 8'h2E;
	localparam logic [7:0] ODD_ADDR_SPARE    = 8'h2F;
	localparam logic [7:0] ODD_ADDR_OUT0     = 8'h30;
	localparam logic [7:0] ODD_ADDR_OUT1     = 8'h31;

	// Field positions
	localparam int ODD_POS_DIV_TYPE  = 1;
	localparam int ODD_POS_POST_LO   = 2;
	localparam int ODD_POS_BANK_PD   = 7;
	localparam int ODD_POS_CTL       = 0;
	localparam int ODD_POS_OUT_PD    = 7;
	localparam int ODD_POS_STYLE     = 2;
	localparam int ODD_POS_SRC       = 0;

	// Reset values
	localparam logic [23:0] ODD_RST_FRAC  = 24'h600000;
	localparam logic [3:0]  ODD_RST_FINT  = 4'h9;
	localparam logic [5:0]  ODD_RST_RATIO = 6'h0D;

	// Reserved limits
	localparam logic [3:0] ODD_FINT_MIN_LEGAL = 4'h5;
	localparam logic [5:0] ODD_RATIO_MAX_CODE = 6'h3B;
	localparam logic [7:0] ODD_RATIO_MAX_VAL  = 8'hDC;
	localparam logic [1:0] ODD_POST_RSVD      = 2'h3;

	// Ratio for code 12h is unknown; value chosen to continue the ascent
	localparam logic [7:0] ODD_RATIO_GAP = 8'h18;

	localparam logic [7:0] ODD_RATIO_TBL [64] = '{
		8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
		8'h09, 8'h0A, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h12, 8'h14,
		8'h15, 8'h16, ODD_RATIO_GAP, 8'h19, 8'h1B, 8'h1C, 8'h1E, 8'h20,
		8'h21, 8'h23, 8'h24, 8'h28, 8'h2A, 8'h2C, 8'h2D, 8'h30,
		8'h32, 8'h36, 8'h37, 8'h38, 8'h3C, 8'h40, 8'h42, 8'h46,
		8'h48, 8'h50, 8'h54, 8'h58, 8'h5A, 8'h60, 8'h64, 8'h6C,
		8'h6E, 8'h70, 8'h78, 8'h80, 8'h84, 8'h8C, 8'h90, 8'hA0,
		8'hB0, 8'hB4, 8'hC8, 8'hDC, 8'h00, 8'h00, 8'h00, 8'h00
	};

	typedef struct packed {
		logic [5:0]  ratio_code;
		logic [23:0] frac;
		logic [3:0]  fint;
		logic [1:0]  post_div;
		logic        div_type;
		logic        src_sel;
		logic        bank_pd;
		logic        out0_pd;
		logic        out0_style;
		logic [1:0]  out0_amp;
		logic        out1_pd;
	} odd_cfg_s;

endpackage

// file: odd_toggle_det.sv
// Purpose: Turns each change of a level into a one-cycle pulse
// Assumes: Input synchronous to clk
// Notes:   Both edges count, as the trigger is a toggle
`timescale 1ns/10ps
module odd_toggle_det (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic level,
	output logic      pulse
);
	logic level_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level_q <= 1'b0;
			pulse   <= 1'b0;
		end else begin
			level_q <= level;
			pulse   <= level ^ level_q;
		end
	end
endmodule // odd_toggle_det

// file: odd_ratio_lut.sv
// Purpose: Maps the coded integer ratio to its divide value
// Assumes: Combinational use only
// Notes:   Reserved codes map to zero
`timescale 1ns/10ps
module odd_ratio_lut
	import odd_pkg::*;
(
	input  wire logic [5:0] code,
	output logic      [7:0] ratio,
	output logic            reserved
);
	always_comb begin
		ratio    = ODD_RATIO_TBL[code];
		reserved = (ratio == 8'h00);
	end
endmodule // odd_ratio_lut

// file: odd_bank_cfg.sv
// Purpose: Register bank and active settings for output bank D
// Assumes: Byte register port driven by the serial-port slave, synchronous inputs
// Notes:   Active ratio code only moves on a resync toggle
`timescale 1ns/10ps
// Operation
// - The 24-bit fraction is kept in three bytes at 0x28 (low), 0x29 (mid) and 0x2A (high).
// - The fractional part of the divide ratio is the fraction field over 2 to the 24.
// - The fraction field resets to 0x600000 and is readable and writable.
// - The 4-bit integer part sits in bits 3:0 at 0x2B, read/write, reset 1001b.
// - Integer-part codes 0 to 4 are reserved, codes 5 to 15 divide by their own value.
// - The 6-bit coded ratio sits in bits 5:0 at 0x2C, read/write, reset 0x0D.
// - A written ratio code only becomes active when the resync trigger is toggled.
// - Ratio code 0 and codes 3C to 3F are reserved, others give ascending fixed ratios.
// - Ratio code 3B selects divide-by-220, the largest ratio.
// - Control-source 0 takes settings from the pins, 1 takes them from the registers.
// - Post-divider 00 divides by 1, 01 by 2, 10 by 4, and 11 is reserved.
// - Bank power-down powers the bank down and puts the second output in high impedance.
module odd_bank_cfg
	import odd_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        resync_trigger,
	input  wire odd_cfg_s    pin_cfg,
	output odd_cfg_s         active_cfg,
	output logic      [7:0]  int_ratio,
	output logic      [27:0] frac_ratio,
	output logic      [2:0]  post_factor,
	output logic             out1_oe,
	output logic             cfg_reserved
);

	odd_cfg_s    regs;
	logic        bank_ctl;
	logic [5:0]  act_code;
	logic        resync_pulse;
	logic [7:0]  lut_ratio;
	logic        lut_rsvd;
	odd_cfg_s    sel_cfg;
	logic [5:0]  next_act_code;
	logic [2:0]  next_post_factor;
	logic        next_reserved;
	logic [7:0]  next_rdata;

	odd_toggle_det u_resync (
		.clk     (ref_clk),
		.reset_n (reset_n),
		.level   (resync_trigger),
		.pulse   (resync_pulse)
	);

	odd_ratio_lut u_lut (
		.code     (act_code),
		.ratio    (lut_ratio),
		.reserved (lut_rsvd)
	);

	// Register writes; reserved bit positions are simply not stored
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			regs            <= '0;
			regs.frac       <= ODD_RST_FRAC;
			regs.fint       <= ODD_RST_FINT;
			regs.ratio_code <= ODD_RST_RATIO;
			bank_ctl        <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				ODD_ADDR_FRAC_LO:  regs.frac[7:0]   <= reg_wdata;
				ODD_ADDR_FRAC_MID: regs.frac[15:8]  <= reg_wdata;
				ODD_ADDR_FRAC_HI:  regs.frac[23:16] <= reg_wdata;
				ODD_ADDR_FINT:     regs.fint <= reg_wdata[3:0];
				ODD_ADDR_RATIO:    regs.ratio_code <= reg_wdata[5:0];
				ODD_ADDR_PATH: begin
					regs.post_div <= reg_wdata[ODD_POS_POST_LO+1:ODD_POS_POST_LO];
					regs.div_type <= reg_wdata[ODD_POS_DIV_TYPE];
					regs.src_sel  <= reg_wdata[ODD_POS_SRC];
				end
				ODD_ADDR_PWR: begin
					regs.bank_pd <= reg_wdata[ODD_POS_BANK_PD];
					bank_ctl     <= reg_wdata[ODD_POS_CTL];
				end
				ODD_ADDR_OUT0: begin
					regs.out0_pd    <= reg_wdata[ODD_POS_OUT_PD];
					regs.out0_style <= reg_wdata[ODD_POS_STYLE];
					regs.out0_amp   <= reg_wdata[1:0];
				end
				ODD_ADDR_OUT1: regs.out1_pd <= reg_wdata[ODD_POS_OUT_PD];
				default: ;
			endcase
		end
	end

	// Read mux; reserved bits and unmapped offsets read as zero
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			ODD_ADDR_FRAC_LO:  next_rdata = regs.frac[7:0];
			ODD_ADDR_FRAC_MID: next_rdata = regs.frac[15:8];
			ODD_ADDR_FRAC_HI:  next_rdata = regs.frac[23:16];
			ODD_ADDR_FINT:     next_rdata = {4'h0, regs.fint};
			ODD_ADDR_RATIO:    next_rdata = {2'h0, regs.ratio_code};
			ODD_ADDR_PATH:     next_rdata = {4'h0, regs.post_div, regs.div_type, regs.src_sel};
			ODD_ADDR_PWR:      next_rdata = {regs.bank_pd, 6'h00, bank_ctl};
			ODD_ADDR_OUT0:     next_rdata = {regs.out0_pd, 4'h0, regs.out0_style, regs.out0_amp};
			ODD_ADDR_OUT1:     next_rdata = {regs.out1_pd, 7'h00};
			default:           next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// Source of every setting follows the control-source bit
	always_comb begin
		sel_cfg = bank_ctl ? regs : pin_cfg;
	end

	// Ratio is taken from the selected source only on a resync toggle,
	// so a divider never sees a half-written code
	always_comb begin
		next_act_code = act_code;
		if (resync_pulse) begin
			next_act_code = sel_cfg.ratio_code;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			act_code <= ODD_RST_RATIO;
		end else begin
			act_code <= next_act_code;
		end
	end

	always_comb begin
		case (sel_cfg.post_div)
			2'h0:    next_post_factor = 3'h1;
			2'h1:    next_post_factor = 3'h2;
			2'h2:    next_post_factor = 3'h4;
			default: next_post_factor = 3'h0;
		endcase
	end

	// Reserved settings are flagged, not corrected: software owns them
	always_comb begin
		next_reserved = lut_rsvd
			| (sel_cfg.fint < ODD_FINT_MIN_LEGAL)
			| (sel_cfg.post_div == ODD_POST_RSVD);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			active_cfg   <= '0;
			int_ratio    <= 8'h00;
			frac_ratio   <= 28'h0;
			post_factor  <= 3'h0;
			out1_oe      <= 1'b0;
			cfg_reserved <= 1'b0;
		end else begin
			active_cfg            <= sel_cfg;
			active_cfg.ratio_code <= act_code;
			int_ratio             <= lut_ratio;
			// Integer part above a 24-bit binary point: value = fint + frac/2^24
			frac_ratio            <= {sel_cfg.fint, sel_cfg.frac};
			post_factor           <= next_post_factor;
			out1_oe               <= !(sel_cfg.bank_pd | sel_cfg.out1_pd);
			cfg_reserved          <= next_reserved;
		end
	end

	AST_FRAC_LO_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		reg_wr && reg_addr == ODD_ADDR_FRAC_LO |=> regs.frac[7:0] == $past(reg_wdata))
		else $error("fraction low byte not stored");

	AST_FRAC_HI_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		reg_wr && reg_addr == ODD_ADDR_FRAC_HI |=> regs.frac[23:16] == $past(reg_wdata)
		&& $stable(regs.frac[15:0]))
		else $error("fraction high byte write wrong");

	AST_FRAC_READBACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
		reg_rd && reg_addr == ODD_ADDR_FRAC_MID |=> reg_rdata == $past(regs.frac[15:8]))
		else $error("fraction mid byte read back wrong");

	AST_RATIO_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!resync_pulse |=> $stable(act_code))
		else $error("active ratio changed without resync");

	AST_RATIO_APPLY: assert property (@(posedge ref_clk) disable iff (!reset_n)
		resync_pulse && bank_ctl |=> act_code == $past(regs.ratio_code)
		##1 active_cfg.ratio_code == $past(act_code))
		else $error("resync did not apply written ratio");

	AST_MAX_RATIO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		act_code == ODD_RATIO_MAX_CODE |=> int_ratio == ODD_RATIO_MAX_VAL)
		else $error("top ratio code is not divide-by-220");

	AST_RSVD_CODE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		act_code > ODD_RATIO_MAX_CODE |=> cfg_reserved && int_ratio == 8'h00)
		else $error("reserved ratio code not flagged");

	AST_SRC_REG: assert property (@(posedge ref_clk) disable iff (!reset_n)
		bank_ctl |=> active_cfg.frac == $past(regs.frac)
		&& active_cfg.bank_pd == $past(regs.bank_pd))
		else $error("register settings not selected");

	AST_SRC_PIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!bank_ctl |=> active_cfg.bank_pd == $past(pin_cfg.bank_pd)
		&& active_cfg.fint == $past(pin_cfg.fint))
		else $error("pin settings not selected");

	AST_POST_DIV: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$past(reset_n) && active_cfg.post_div != ODD_POST_RSVD
		|-> post_factor == (3'h1 << active_cfg.post_div))
		else $error("post divider factor wrong");

	AST_PD_HIZ: assert property (@(posedge ref_clk) disable iff (!reset_n)
		active_cfg.bank_pd |-> !out1_oe)
		else $error("second output driven while bank powered down");

	AST_FINT_RSVD: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$past(reset_n) && active_cfg.fint < ODD_FINT_MIN_LEGAL |-> cfg_reserved)
		else $error("reserved integer part not flagged");

	AST_FRAC_TOTAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
		bank_ctl |=> frac_ratio == {$past(regs.fint), $past(regs.frac)})
		else $error("total fractional ratio mismatched");

endmodule // odd_bank_cfg

// file: tb_top.sv
// Purpose: Self-checking bench for the bank D configuration block
// Assumes: Strobes sampled on the edge after they are raised, settings settle one edge later
// Notes:   Each expectation is queued by the driver and taken off when its result shows
`timescale 1ns/10ps
module tb_top
	import odd_pkg::*;
;
	typedef struct {
		int          sel;
		logic [43:0] exp;
	} odd_note_s;

	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        resync_trigger = 1'b0;
	odd_cfg_s    pin_cfg = '0;
	odd_cfg_s    active_cfg;
	odd_cfg_s    pc;
	logic [7:0]  int_ratio;
	logic [27:0] frac_ratio;
	logic [2:0]  post_factor;
	logic        out1_oe;
	logic        cfg_reserved;
	logic        look = 1'b0;
	logic        rd_seen = 1'b0;
	logic [63:0] rnd;
	logic [7:0]  fb [3];
	logic [7:0]  prev;
	int          err_count = 0;
	int          checks_done = 0;
	integer      seed = 32'ha8b15187;
	odd_note_s   note_q [$];
	odd_note_s   cur;
	string       nm [7] = '{"reg_rdata", "int_ratio", "frac_ratio", "post_factor",
		"out1_oe", "cfg_reserved", "active_cfg"};
	logic [7:0]  rst_v [10] = '{8'h00, 8'h00, 8'h60, 8'h09, 8'h0D,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  ff_v [10] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h3F,
		8'h0F, 8'h81, 8'h00, 8'h87, 8'h80};
	logic [7:0]  pf [4] = '{8'h01, 8'h02, 8'h04, 8'h00};
	logic [7:0]  cd [6] = '{8'h3B, 8'h00, 8'h01, 8'h3C, 8'h3F, 8'h07};
	logic [7:0]  rv [6] = '{8'hDC, 8'h00, 8'h01, 8'h00, 8'h00, 8'h08};

	always #20 ref_clk = ~ref_clk;

	odd_bank_cfg u_odd_bank_cfg (
		.ref_clk        (ref_clk),
		.reset_n        (reset_n),
		.reg_addr       (reg_addr),
		.reg_wr         (reg_wr),
		.reg_wdata      (reg_wdata),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.resync_trigger (resync_trigger),
		.pin_cfg        (pin_cfg),
		.active_cfg     (active_cfg),
		.int_ratio      (int_ratio),
		.frac_ratio     (frac_ratio),
		.post_factor    (post_factor),
		.out1_oe        (out1_oe),
		.cfg_reserved   (cfg_reserved)
	);

	task automatic check(input string what, input logic [43:0] seen, input logic [43:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [43:0] seen_of(input int s);
		case (s)
			0: return {36'h0, reg_rdata};
			1: return {36'h0, int_ratio};
			2: return {16'h0, frac_ratio};
			3: return {41'h0, post_factor};
			4: return {43'h0, out1_oe};
			5: return {43'h0, cfg_reserved};
			default: return active_cfg;
		endcase
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		note_q.push_back('{0, {36'h0, e}});
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	// Settled outputs are looked at on the falling edge after look rises
	task automatic probe(input int sel, input logic [43:0] e, input int n);
		repeat (n) @(posedge ref_clk);
		look <= 1'b1;
		note_q.push_back('{sel, e});
		@(posedge ref_clk);
		look <= 1'b0;
	endtask

	always @(posedge ref_clk) rd_seen <= reg_rd;

	always @(negedge ref_clk) begin
		if (rd_seen || look) begin
			if (note_q.size() == 0) begin
				err_count++;
				$display("ERROR result with no note expected none seen one");
			end else begin
				cur = note_q.pop_front();
				check(nm[cur.sel], seen_of(cur.sel), cur.exp);
			end
		end
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#120000;
		err_count++;
		end_of_test();
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++) rd(8'h28 + i[7:0], rst_v[i]);
		rd(8'h40, 8'h00);
		probe(1, 44'h10, 1);
		for (int i = 0; i < 10; i++) begin
			wr(8'h28 + i[7:0], ff_v[i]);
			rd(8'h28 + i[7:0], ff_v[i]);
		end
		probe(4, 44'h0, 1);
		wr(8'h2E, 8'h01);
		wr(8'h31, 8'h00);
		wr(8'h2D, 8'h00);
		probe(4, 44'h1, 1);
		probe(1, 44'h10, 1);
		for (int i = 0; i < 3; i++) begin
			rnd[31:0] = $random(seed);
			fb[i] = rnd[7:0];
			wr(8'h28 + i[7:0], fb[i]);
		end
		wr(8'h2B, 8'h05);
		probe(2, {16'h0, 4'h5, fb[2], fb[1], fb[0]}, 1);
		rd(8'h28, fb[0]);
		// Every integer-part code, reserved ones included
		for (int f = 0; f < 16; f++) begin
			wr(8'h2B, f[7:0]);
			probe(5, {43'h0, f < 5}, 1);
		end
		for (int p = 0; p < 4; p++) begin
			wr(8'h2D, p[7:0] << 2);
			probe(3, {36'h0, pf[p]}, 1);
			probe(5, {43'h0, p == 3}, 1);
		end
		wr(8'h2D, 8'h00);
		prev = 8'h10;
		for (int i = 0; i < 6; i++) begin
			wr(8'h2C, cd[i]);
			probe(1, {36'h0, prev}, 1);
			resync_trigger <= ~resync_trigger;
			probe(1, {36'h0, rv[i]}, 4);
			probe(5, {43'h0, rv[i] == 8'h00}, 1);
			prev = rv[i];
		end
		wr(8'h2E, 8'h00);
		rnd = {$random(seed), $random(seed)};
		pc = rnd[43:0];
		pc.ratio_code = 6'h3B;
		pin_cfg <= pc;
		probe(6, {cd[5][5:0], pc[37:0]}, 2);
		resync_trigger <= ~resync_trigger;
		probe(1, 44'hDC, 4);
		probe(6, pc, 1);
		end_of_test();
	end
endmodule // tb_top
